// file: hw/mebc_pkg.sv
// shared constants, types and helpers for the external bus control block
package mebc_pkg;

	// =====================================================================
	// clock and timing
	// =====================================================================
	localparam int MEBC_MCLK_HZ       = 50_000_000;
	localparam int MEBC_STATE_DIV     = 3;   // master clocks per state clock
	localparam int MEBC_CYCLE_STATES  = 5;   // state clocks per machine cycle
	localparam int MEBC_MAX_CYCLES    = 2;   // machine cycles per instruction, at most

	// =====================================================================
	// widths and field positions
	// =====================================================================
	localparam int MEBC_ADDR_W        = 12;
	localparam int MEBC_DATA_W        = 8;
	localparam int MEBC_LOW_ADDR_MSB  = 7;   // address bits on the data bus port
	localparam int MEBC_HIGH_ADDR_LSB = 8;   // address bits on the second port
	localparam int MEBC_HIGH_ADDR_MSB = 11;
	localparam int MEBC_HIGH_ADDR_W   = 4;

	// =====================================================================
	// reset and idle values of the pins
	// =====================================================================
	localparam logic                   MEBC_STROBE_IDLE = 1'b1;  // active-low strobes idle high
	localparam logic                   MEBC_OE_OFF      = 1'b1;  // output enable low means driving
	localparam logic                   MEBC_ALE_IDLE    = 1'b0;
	localparam logic [MEBC_DATA_W-1:0] MEBC_DATA_ZERO   = 8'h00;
	localparam logic [3:0]             MEBC_NIB_ZERO    = 4'h0;

	// =====================================================================
	// machine cycle states, gray coded from S1 through S5
	// =====================================================================
	typedef enum logic [2:0] {
		MEBC_S1 = 3'h0,
		MEBC_S2 = 3'h1,
		MEBC_S3 = 3'h3,
		MEBC_S4 = 3'h2,
		MEBC_S5 = 3'h6
	} mebc_state_t;

	// data transfer kinds for the second machine cycle
	typedef enum logic [1:0] {
		MEBC_DOP_NONE  = 2'h0,
		MEBC_DOP_READ  = 2'h1,
		MEBC_DOP_WRITE = 2'h2
	} mebc_dop_t;

	// requests from the processor core
	typedef struct packed {
		logic [MEBC_ADDR_W-1:0] fetch_addr;
		logic                   two_cycle;
		mebc_dop_t              dop;
		logic [MEBC_DATA_W-1:0] data_addr;
		logic [MEBC_DATA_W-1:0] wdata;
		logic                   t0_clk_en;
		logic                   int_enable;
		logic                   int_return;
	} mebc_core_req_t;

	// answers to the processor core
	typedef struct packed {
		logic [MEBC_DATA_W-1:0] instr;
		logic                   instr_valid;
		logic [MEBC_DATA_W-1:0] rdata;
		logic                   rdata_valid;
		logic                   boundary;
		logic                   branch_cond;
		logic                   int_take;
		logic                   in_service;
		logic                   ext_mode;
	} mebc_core_rsp_t;

	// outputs toward the pins
	typedef struct packed {
		logic                        ale;
		logic                        program_store_strobe_n;
		logic                        read_strobe_n;
		logic                        write_strobe_n;
		logic [MEBC_DATA_W-1:0]      data_bus_port_out;
		logic                        data_bus_port_oe_n;
		logic [MEBC_HIGH_ADDR_W-1:0] second_port_addr;
		logic                        test_sense_zero_out;
		logic                        test_sense_zero_oe_n;
	} mebc_pins_t;

	// next state along the machine cycle
	function automatic mebc_state_t mebc_next_state(input mebc_state_t st);
		case (st)
			MEBC_S1: mebc_next_state = MEBC_S2;
			MEBC_S2: mebc_next_state = MEBC_S3;
			MEBC_S3: mebc_next_state = MEBC_S4;
			MEBC_S4: mebc_next_state = MEBC_S5;
			default: mebc_next_state = MEBC_S1;
		endcase
	endfunction

endpackage

// file: hw/mebc_timing.sv
// state clock divider and machine cycle state counter
`timescale 1ns/1ps
module mebc_timing #(
	parameter int DIV = mebc_pkg::MEBC_STATE_DIV
) (
	// clock and reset
	input  wire logic                mclk,
	input  wire logic                reset_n,
	// control
	input  wire logic                hold,
	// timing outputs
	output mebc_pkg::mebc_state_t    state,
	output logic                     tick,
	output logic                     phase1
);
	import mebc_pkg::*;

	logic [3:0]  div_reg;
	mebc_state_t state_reg;
	logic        phase1_reg;

	// =====================================================================
	// divider
	// =====================================================================
	// tick marks the last master clock of a state
	assign tick   = (div_reg == 4'(DIV - 1));
	assign state  = state_reg;
	assign phase1 = phase1_reg;

	// held counter freezes the whole cycle, used for single stepping
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			div_reg <= 4'h0;
		end else if (!hold) begin
			div_reg <= tick ? 4'h0 : div_reg + 4'h1;
		end
	end

	// state walk, one step per state clock
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= MEBC_S5;
		end else if (!hold && tick) begin
			state_reg <= mebc_next_state(state_reg);
		end
	end

	// phase-one clock: high during the first third of each state
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			phase1_reg <= 1'b0;
		end else if (!hold) begin
			phase1_reg <= tick;
		end
	end

endmodule

// file: hw/mebc_bus_ctrl.sv
// pin-level bus control of the single-chip microcomputer
// =========================================================================
// What this block does
// [RL1] selected by the core, the test/sense pin outputs the phase-one state clock
// [RL2] otherwise the test/sense pin is sampled as the branch condition
// [RL3] reset holds every processor and pin state at its initial value
// [RL4] single-step input halts at instruction boundaries, address-latch strobe marks them
// [RL5] a low interrupt input is taken as an external interrupt request
// [RL6] one interrupt level only; no interrupt is taken while one is serviced
// [RL7] external-fetch select high during reset selects external program operation
// [RL8] read strobe pulses to qualify each data input from the data bus port
// [RL9] read strobe acts as read enable of external data memory
// [RL10] program-store strobe asserted in each external fetch, instruction sampled then
// [RL11] every instruction takes one or two machine cycles, never more
// [RL12] the variant without on-chip program memory always fetches externally
// [RL13] address-latch strobe pulses at the start of every machine cycle
// [RL14] address-latch strobe qualifies low address bits on the data bus port
// [RL15] address bits eight to eleven go out on the second port in external fetches
// [RL16] write strobe pulses to qualify data driven out on the data bus port
// [RL17] program source captured in reset stays until the next reset
// =========================================================================
`timescale 1ns/1ps
module mebc_bus_ctrl #(
	parameter bit ROMLESS = 1'b0,
	parameter int DIV     = mebc_pkg::MEBC_STATE_DIV
) (
	// clock and reset
	input  wire logic                                  mclk,
	input  wire logic                                  reset_n,
	// control pins
	input  wire logic                                  single_step_n,
	input  wire logic                                  interrupt_req_n,
	input  wire logic                                  external_fetch_select,
	input  wire logic                                  test_sense_zero_in,
	// data bus port input and on-chip program memory data
	input  wire logic [mebc_pkg::MEBC_DATA_W-1:0]      data_bus_port_in,
	input  wire logic [mebc_pkg::MEBC_DATA_W-1:0]      rom_data,
	// core side
	input  mebc_pkg::mebc_core_req_t                   core_req,
	output mebc_pkg::mebc_core_rsp_t                   core_rsp,
	// pins
	output mebc_pkg::mebc_pins_t                       pins
);
	import mebc_pkg::*;

	// =====================================================================
	// declarations
	// =====================================================================
	mebc_state_t    state;
	logic           tick;
	logic           phase1;
	logic           hold;
	logic           step;
	logic           last_cycle;
	logic           boundary_tick;
	mebc_state_t    nst;

	logic           fetch_sel_cap;     // no reset: only follows the pin while in reset
	logic           started_reg;
	logic           ext_mode_reg;
	logic           second_reg;
	logic           two_cycle_reg;
	mebc_dop_t      dop_reg;
	logic           in_service_reg;
	mebc_core_rsp_t rsp_reg;
	mebc_pins_t     pins_reg;

	assign core_rsp = rsp_reg;
	assign pins     = pins_reg;

	// true when this cycle fetches from outside
	function automatic logic ext_fetch(input logic ext, input logic second);
		ext_fetch = ext && !second;
	endfunction

	// =====================================================================
	// state timing
	// =====================================================================
	mebc_timing #(
		.DIV     (DIV)
	) u_timing (
		.mclk    (mclk),
		.reset_n (reset_n),
		.hold    (hold),
		.state   (state),
		.tick    (tick),
		.phase1  (phase1)
	);

	// [RL11] at most two cycles
	assign last_cycle    = second_reg || !two_cycle_reg;
	assign boundary_tick = tick && (state == MEBC_S5) && last_cycle;
	// [RL4] freeze at boundary
	assign hold          = boundary_tick && !single_step_n;
	assign step          = tick && !hold;
	assign nst           = mebc_next_state(state);

	// =====================================================================
	// program source
	// =====================================================================
	// [RL7] sample select in reset
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			fetch_sel_cap <= external_fetch_select;
		end
	end

	// [RL17] latched once after release, so later pin changes are ignored
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			started_reg  <= 1'b0;
			ext_mode_reg <= 1'b0;
		end else if (!started_reg) begin
			started_reg  <= 1'b1;
			// [RL12] romless forces external
			ext_mode_reg <= fetch_sel_cap || ROMLESS;
		end
	end

	// =====================================================================
	// instruction length tracking
	// =====================================================================
	// [RL11] second cycle only after a two-cycle fetch
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			second_reg    <= 1'b0;
			two_cycle_reg <= 1'b0;
			dop_reg       <= MEBC_DOP_NONE;
		end else if (step) begin
			if (nst == MEBC_S1) begin
				second_reg <= !second_reg && two_cycle_reg;
				dop_reg    <= (!second_reg && two_cycle_reg) ? core_req.dop : MEBC_DOP_NONE;
			end else if (nst == MEBC_S4 && !second_reg) begin
				two_cycle_reg <= core_req.two_cycle;
			end
		end
	end

	// =====================================================================
	// interrupt
	// =====================================================================
	// [RL5] [RL6] single level: taken only when idle, cleared by return
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			in_service_reg <= 1'b0;
		end else if (step && boundary_tick && !interrupt_req_n
				&& core_req.int_enable && !in_service_reg) begin
			in_service_reg <= 1'b1;
		end else if (core_req.int_return) begin
			in_service_reg <= 1'b0;
		end
	end

	// =====================================================================
	// core answers
	// =====================================================================
	// [RL3] reset holds answers at zero
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			rsp_reg <= '0;
		end else begin
			rsp_reg.instr_valid <= 1'b0;
			rsp_reg.rdata_valid <= 1'b0;
			rsp_reg.boundary    <= 1'b0;
			rsp_reg.int_take    <= 1'b0;
			rsp_reg.in_service  <= in_service_reg;
			rsp_reg.ext_mode    <= ext_mode_reg;
			// [RL2] sense pin as condition
			if (!core_req.t0_clk_en) begin
				rsp_reg.branch_cond <= test_sense_zero_in;
			end
			if (step) begin
				// instruction byte taken at the end of state three
				if (nst == MEBC_S4 && !second_reg) begin
					// [RL10] external byte read under strobe
					rsp_reg.instr       <= ext_mode_reg ? data_bus_port_in : rom_data;
					rsp_reg.instr_valid <= 1'b1;
				end
				// [RL8] [RL9] read data taken at the end of the strobe
				if (nst == MEBC_S5 && dop_reg == MEBC_DOP_READ) begin
					rsp_reg.rdata       <= data_bus_port_in;
					rsp_reg.rdata_valid <= 1'b1;
				end
				if (boundary_tick) begin
					rsp_reg.boundary <= 1'b1;
					rsp_reg.int_take <= !interrupt_req_n && core_req.int_enable && !in_service_reg;
				end
			end
		end
	end

	// =====================================================================
	// test/sense pin
	// =====================================================================
	// [RL1] phase-one clock out, one pulse per state, one third of the master clock rate
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			pins_reg.test_sense_zero_out  <= 1'b0;
			pins_reg.test_sense_zero_oe_n <= MEBC_OE_OFF;
		end else begin
			pins_reg.test_sense_zero_out  <= core_req.t0_clk_en && phase1;
			pins_reg.test_sense_zero_oe_n <= !core_req.t0_clk_en;
		end
	end

	// =====================================================================
	// address latch strobe
	// =====================================================================
	// [RL13] pulse in state one; [RL4] stays high while stepped halt lasts
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			pins_reg.ale <= MEBC_ALE_IDLE;
		end else if (hold) begin
			pins_reg.ale <= 1'b1;
		end else if (step) begin
			pins_reg.ale <= (nst == MEBC_S1);
		end
	end

	// =====================================================================
	// program store strobe
	// =====================================================================
	// [RL10] low across states two and three of an external fetch
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			pins_reg.program_store_strobe_n <= MEBC_STROBE_IDLE;
		end else if (step) begin
			if (nst == MEBC_S2 && ext_fetch(ext_mode_reg, second_reg)) begin
				pins_reg.program_store_strobe_n <= 1'b0;
			end else if (nst == MEBC_S4) begin
				pins_reg.program_store_strobe_n <= MEBC_STROBE_IDLE;
			end
		end
	end

	// =====================================================================
	// read and write strobes
	// =====================================================================
	// [RL8] [RL16] low during state four of a data cycle
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			pins_reg.read_strobe_n  <= MEBC_STROBE_IDLE;
			pins_reg.write_strobe_n <= MEBC_STROBE_IDLE;
		end else if (step) begin
			pins_reg.read_strobe_n  <= !(nst == MEBC_S4 && dop_reg == MEBC_DOP_READ);
			pins_reg.write_strobe_n <= !(nst == MEBC_S4 && dop_reg == MEBC_DOP_WRITE);
		end
	end

	// =====================================================================
	// data bus port and second port drive
	// =====================================================================
	// data is held through state five so it outlasts the write strobe edge
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			pins_reg.data_bus_port_out  <= MEBC_DATA_ZERO;
			pins_reg.data_bus_port_oe_n <= MEBC_OE_OFF;
			pins_reg.second_port_addr   <= MEBC_NIB_ZERO;
		end else if (step) begin
			case (nst)
				MEBC_S1: begin
					// [RL14] low address under the latch strobe
					if (ext_fetch(ext_mode_reg, !second_reg && two_cycle_reg)) begin
						pins_reg.data_bus_port_out  <= core_req.fetch_addr[MEBC_LOW_ADDR_MSB:0];
						pins_reg.data_bus_port_oe_n <= 1'b0;
						// [RL15] high address nibble
						pins_reg.second_port_addr   <=
							core_req.fetch_addr[MEBC_HIGH_ADDR_MSB:MEBC_HIGH_ADDR_LSB];
					end else if (!second_reg && two_cycle_reg && core_req.dop != MEBC_DOP_NONE) begin
						pins_reg.data_bus_port_out  <= core_req.data_addr;
						pins_reg.data_bus_port_oe_n <= 1'b0;
					end else begin
						pins_reg.data_bus_port_oe_n <= MEBC_OE_OFF;
					end
				end
				MEBC_S2: begin
					// [RL9] [RL10] bus released for the memory to drive
					pins_reg.data_bus_port_oe_n <= MEBC_OE_OFF;
				end
				MEBC_S4: begin
					// [RL16] write data out
					if (dop_reg == MEBC_DOP_WRITE) begin
						pins_reg.data_bus_port_out  <= core_req.wdata;
						pins_reg.data_bus_port_oe_n <= 1'b0;
					end
				end
				MEBC_S3, MEBC_S5: begin
					pins_reg.data_bus_port_oe_n <= pins_reg.data_bus_port_oe_n;
				end
				default: begin
					pins_reg.data_bus_port_oe_n <= MEBC_OE_OFF;
				end
			endcase
		end
	end

endmodule

// file: bench/mebc_memory_model.sv
// far-side model: address latch, external program store and data store
`timescale 1ns/1ps
module mebc_memory_model (
	// clock
	input  wire logic            mclk,
	// device pins
	input  mebc_pkg::mebc_pins_t pins,
	// bus level seen by the device
	output logic [7:0]           data_bus_port_in
);
	import mebc_pkg::*;
	logic [11:0] addr_latch;
	logic [7:0]  data_mem [256];
	logic [7:0]  last_drive = 8'h00;
	// latch the address while ale is high and the device drives
	always_ff @(posedge mclk) begin
		if (pins.ale && !pins.data_bus_port_oe_n)
			addr_latch <= {pins.second_port_addr, pins.data_bus_port_out};
		if (!pins.write_strobe_n)
			data_mem[addr_latch[7:0]] <= pins.data_bus_port_out;
		last_drive <= data_bus_port_in;
	end
	// memory drives only under its strobe; an undriven bus keeps changing
	always_comb begin
		if (!pins.data_bus_port_oe_n)
			data_bus_port_in = pins.data_bus_port_out;
		else if (!pins.program_store_strobe_n)
			data_bus_port_in = addr_latch[7:0] ^ {addr_latch[11:8], 4'h9};
		else if (!pins.read_strobe_n)
			data_bus_port_in = data_mem[addr_latch[7:0]];
		else
			data_bus_port_in = ~last_drive;
	end
endmodule

// file: bench/mebc_bus_ctrl_properties.sv
// timing relations watched at the ports of the bus control block
`timescale 1ns/1ps
module mebc_bus_ctrl_props #(
	parameter bit ROMLESS = 1'b0,
	parameter int DIV     = 3
) (
	// clock and reset
	input wire logic                  mclk,
	input wire logic                  reset_n,
	// control pins
	input wire logic                  single_step_n,
	input wire logic                  interrupt_req_n,
	input wire logic                  external_fetch_select,
	input wire logic                  test_sense_zero_in,
	// data sources
	input wire logic [7:0]            data_bus_port_in,
	input wire logic [7:0]            rom_data,
	// core side and pins
	input mebc_pkg::mebc_core_req_t   core_req,
	input mebc_pkg::mebc_core_rsp_t   core_rsp,
	input mebc_pkg::mebc_pins_t       pins
);
	import mebc_pkg::*;
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!reset_n);
	// ==================================================================
	// strobes
	// ==================================================================
	AST_ALE_PERIOD: assert property ($fell(pins.ale) |-> (!pins.ale)[*8] ##1 (!pins.ale)[*4] ##1 pins.ale)
		else $error("ale low time not twelve clocks");
	AST_PROGRAM_STORE_STROBE_WIDTH: assert property ($fell(pins.program_store_strobe_n) |-> $fell(pins.ale) ##1
		(!pins.program_store_strobe_n)[*5] ##1 pins.program_store_strobe_n) else $error("fetch strobe shape");
	AST_PROGRAM_STORE_STROBE_EXT_ONLY: assert property (!core_rsp.ext_mode |-> pins.program_store_strobe_n)
		else $error("fetch strobe in internal mode");
	AST_RD_WIDTH: assert property ($fell(pins.read_strobe_n) |-> (!pins.read_strobe_n)[*3] ##1
		pins.read_strobe_n ##[0:1] core_rsp.rdata_valid) else $error("read strobe shape");
	AST_RD_RELEASED: assert property (!pins.read_strobe_n |-> pins.data_bus_port_oe_n)
		else $error("device drives bus under read");
	AST_WR_DRIVES: assert property (!pins.write_strobe_n |-> !pins.data_bus_port_oe_n)
		else $error("write strobe without data");
	// ==================================================================
	// test/sense, interrupt, mode, instruction length
	// ==================================================================
	AST_T0_PHASE: assert property ($rose(pins.test_sense_zero_out) |=> (!pins.test_sense_zero_out)[*2])
		else $error("state clock not one in three");
	AST_BRANCH: assert property (!core_req.t0_clk_en && !$past(core_req.t0_clk_en) && $past(reset_n) |->
		core_rsp.branch_cond == $past(test_sense_zero_in)) else $error("branch condition lags");
	AST_INT_LEVEL: assert property (core_rsp.int_take |-> !$past(core_rsp.in_service))
		else $error("interrupt nested");
	AST_INT_REQ: assert property (core_rsp.int_take |-> !$past(interrupt_req_n))
		else $error("interrupt without request");
	AST_EXT_HOLD: assert property ($past(reset_n, 4) |-> $stable(core_rsp.ext_mode))
		else $error("program source changed");
	AST_INSTR_LEN: assert property (core_rsp.boundary && single_step_n |->
		(##15 core_rsp.boundary) or (##30 core_rsp.boundary) or (##[1:30] !single_step_n))
		else $error("instruction length");
endmodule
bind mebc_bus_ctrl mebc_bus_ctrl_props #(.ROMLESS(ROMLESS), .DIV(DIV)) props_u (
	.mclk(mclk), .reset_n(reset_n), .single_step_n(single_step_n), .interrupt_req_n(interrupt_req_n),
	.external_fetch_select(external_fetch_select), .test_sense_zero_in(test_sense_zero_in),
	.data_bus_port_in(data_bus_port_in), .rom_data(rom_data), .core_req(core_req),
	.core_rsp(core_rsp), .pins(pins));

// file: bench/mebc_bus_ctrl_test.sv
// self-checking bench for the bus control block with far-side memory
`timescale 1ns/1ps
module mebc_bus_ctrl_test;
	import mebc_pkg::*;
	logic           mclk = 1'b0;
	logic           reset_n, single_step_n, interrupt_req_n, external_fetch_select, sense_drive;
	wire logic      test_sense_zero_in;
	logic [7:0]     data_bus_port_in, rom_data;
	mebc_core_req_t core_req;
	mebc_core_rsp_t core_rsp;
	mebc_pins_t     pins;
	int             n_mismatch = 0;
	int             checked = 0;
	// ==================================================================
	// clock, pin level, instances
	// ==================================================================
	always #10 mclk = ~mclk;
	// the pin shows the device clock while it drives, else the bench level
	assign test_sense_zero_in = pins.test_sense_zero_oe_n ? sense_drive : pins.test_sense_zero_out;
	mebc_bus_ctrl dut_u (.mclk(mclk), .reset_n(reset_n), .single_step_n(single_step_n),
		.interrupt_req_n(interrupt_req_n), .external_fetch_select(external_fetch_select),
		.test_sense_zero_in(test_sense_zero_in), .data_bus_port_in(data_bus_port_in),
		.rom_data(rom_data), .core_req(core_req), .core_rsp(core_rsp), .pins(pins));
	mebc_memory_model mem_u (.mclk(mclk), .pins(pins), .data_bus_port_in(data_bus_port_in));
	// ==================================================================
	// shared tasks
	// ==================================================================
	task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// bounded wait for a pulse; 0 instr, 1 rdata, 2 boundary, 3 interrupt taken
	task automatic wait_pulse(input int sel, input int limit);
		logic hit;
		hit = 1'b0;
		for (int i = 0; i < limit && hit !== 1'b1; i++) begin
			@(negedge mclk);
			hit = sel == 0 ? core_rsp.instr_valid : sel == 1 ? core_rsp.rdata_valid :
				sel == 2 ? core_rsp.boundary : core_rsp.int_take;
		end
		check("awaited pulse", hit, 1'b1);
	endtask
	// count the cycles in which a pin, or the interrupt take answer, sits at a level
	task automatic count_level(input int sel, input int span, output int hits);
		hits = 0;
		repeat (span) begin
			@(negedge mclk);
			hits += sel == 0 ? pins.ale : sel == 1 ? !pins.program_store_strobe_n :
				sel == 2 ? !pins.read_strobe_n : sel == 3 ? pins.test_sense_zero_out : core_rsp.int_take;
		end
	endtask
	task automatic do_reset(input logic sel);
		reset_n = 1'b0;
		external_fetch_select = sel;
		repeat (4) @(negedge mclk);
		// every strobe idle and nothing driven while held
		check("idle pins", {pins.ale, pins.program_store_strobe_n, pins.read_strobe_n, pins.write_strobe_n,
			pins.data_bus_port_oe_n, pins.test_sense_zero_oe_n}, 6'h1f);
		check("core answers", core_rsp, '0);
		reset_n = 1'b1;
	endtask
	// ==================================================================
	// scenarios
	// ==================================================================
	task automatic test_fetch();
		logic [11:0] addrs [3] = '{12'h000, 12'ha5c, 12'hfff};
		external_fetch_select = 1'b0;
		foreach (addrs[i]) begin
			wait_pulse(0, 40);
			core_req.fetch_addr = addrs[i];
			wait_pulse(0, 40);
			check("fetched byte", core_rsp.instr, addrs[i][7:0] ^ {addrs[i][11:8], 4'h9});
			check("latched address", mem_u.addr_latch, addrs[i]);
			check("high address", pins.second_port_addr, addrs[i][11:8]);
			check("external mode", core_rsp.ext_mode, 1'b1);
		end
	endtask
	task automatic test_data();
		int hits;
		core_req.two_cycle = 1'b1;
		core_req.dop = MEBC_DOP_WRITE;
		core_req.data_addr = 8'h3c;
		core_req.wdata = 8'h96;
		wait_pulse(2, 80);
		wait_pulse(2, 80);
		check("stored byte", mem_u.data_mem[8'h3c], 8'h96);
		core_req.dop = MEBC_DOP_READ;
		wait_pulse(1, 80);
		check("read byte", core_rsp.rdata, 8'h96);
		// a one-cycle instruction ignores its transfer request
		core_req.two_cycle = 1'b0;
		wait_pulse(2, 80);
		wait_pulse(2, 80);
		count_level(2, 45, hits);
		check("read strobes", hits, 0);
		core_req.dop = MEBC_DOP_NONE;
	endtask
	task automatic test_sense();
		int hits;
		sense_drive = 1'b1;
		repeat (3) @(negedge mclk);
		check("branch high", core_rsp.branch_cond, 1'b1);
		sense_drive = 1'b0;
		repeat (3) @(negedge mclk);
		check("branch low", core_rsp.branch_cond, 1'b0);
		core_req.t0_clk_en = 1'b1;
		repeat (6) @(negedge mclk);
		count_level(3, 9, hits);
		check("state clock highs", hits, 3);
		check("sense driven", pins.test_sense_zero_oe_n, 1'b0);
		core_req.t0_clk_en = 1'b0;
		repeat (3) @(negedge mclk);
		check("sense released", pins.test_sense_zero_oe_n, 1'b1);
	endtask
	task automatic test_interrupt();
		int hits;
		core_req.int_enable = 1'b1;
		interrupt_req_n = 1'b0;
		wait_pulse(3, 80);
		// service level reaches the answer one clock after the take pulse
		@(negedge mclk);
		check("in service", core_rsp.in_service, 1'b1);
		count_level(4, 60, hits);
		check("nested takes", hits, 0);
		interrupt_req_n = 1'b1;
		core_req.int_return = 1'b1;
		@(negedge mclk);
		core_req.int_return = 1'b0;
		repeat (2) @(negedge mclk);
		check("service ended", core_rsp.in_service, 1'b0);
		count_level(4, 45, hits);
		check("takes without request", hits, 0);
		core_req.int_enable = 1'b0;
	endtask
	task automatic test_step();
		int hits;
		single_step_n = 1'b0;
		// a held boundary gives no pulse, so wait past the longest instruction
		repeat (40) @(negedge mclk);
		count_level(0, 30, hits);
		check("ale held in step", hits, 30);
		single_step_n = 1'b1;
		wait_pulse(2, 80);
	endtask
	task automatic test_internal();
		int hits;
		do_reset(1'b0);
		wait_pulse(0, 60);
		check("internal byte", core_rsp.instr, rom_data);
		check("internal mode", core_rsp.ext_mode, 1'b0);
		count_level(1, 45, hits);
		check("fetch strobes", hits, 0);
		count_level(0, 30, hits);
		check("ale per two cycles", hits, 6);
	endtask
	// ==================================================================
	// main sequence and watchdog
	// ==================================================================
	initial begin
		reset_n = 1'b0;
		single_step_n = 1'b1;
		interrupt_req_n = 1'b1;
		external_fetch_select = 1'b1;
		sense_drive = 1'b0;
		rom_data = 8'h7e;
		core_req = '0;
		do_reset(1'b1);
		test_fetch();
		test_data();
		test_sense();
		test_interrupt();
		test_step();
		test_internal();
		conclude();
	end
	// a hang far beyond the fewer than 1200 cycles needed ends the run
	initial begin
		#400_000;
		n_mismatch++;
		conclude();
	end
endmodule
